// [rcw_pkg.sv]
package rcw_pkg;

  // serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 8;
  localparam logic [7:0] CMD_REFRESH = 8'h5a;
  localparam logic [7:0] CMD_RD_RANDOM = 8'h1b;
  localparam logic [6:0] INT_REG_ADDR = 7'h36;
  localparam logic [7:0] STATUS_HIGH = 8'h00;

  // challenge generator
  localparam logic [7:0] LFSR_SEED = 8'h5d;
  localparam logic [7:0] LFSR_TAPS = 8'hb8;

  // timing
  localparam int CLK_KHZ = 40000;
  localparam int WD_PERIOD_US = 64000;
  localparam int WD_PERIOD_CYC = (WD_PERIOD_US * (CLK_KHZ / 1000));
  localparam int INT_PERIODS = 2;

  // how many partial writes make one refresh
  typedef enum logic [1:0] {
    RCW_NWR_ONE = 2'h0,
    RCW_NWR_TWO = 2'h1,
    RCW_NWR_FOUR = 2'h3
  } rcw_nwr_t;

  typedef enum logic [3:0] {
    RCW_MODE_PWR_DOWN = 4'h0,
    RCW_MODE_INIT_RESET = 4'h1,
    RCW_MODE_INIT = 4'h3,
    RCW_MODE_RESET = 4'h2,
    RCW_MODE_NORM_REQ = 4'h6,
    RCW_MODE_NORMAL = 4'h7,
    RCW_MODE_LP_OFF = 4'h5,
    RCW_MODE_SLEEP_KEPT = 4'h4,
    RCW_MODE_SAFE = 4'hc,
    RCW_MODE_FLASH = 4'hd
  } rcw_mode_t;

  typedef enum logic [1:0] {
    RCW_IO_OFF = 2'h0,
    RCW_IO_HS = 2'h1,
    RCW_IO_LS = 2'h2
  } rcw_iocfg_t;

  // supply and transceiver switches driven per mode
  typedef struct packed {
    logic vddOn;
    logic vddLowCurrent;
    logic canSupplyOn;
    logic io0Hs;
    logic io0Ls;
    logic io1Hs;
    logic io1Ls;
    logic canTxEn;
    logic canRxEn;
    logic canWakeEn;
    logic canTermGnd;
    logic linPullup;
    logic linTxEn;
    logic linRxEn;
    logic linWakeEn;
    logic linTermEn;
  } rcw_map_t;

  // bits of the inverted challenge that a partial write must carry
  function automatic logic [7:0] rcw_mask(input rcw_nwr_t nwr, input logic [1:0] pos);
    logic [7:0] m;
    m = 8'hff;
    if (nwr == RCW_NWR_TWO) begin
      m = pos[0] ? 8'h0f : 8'hf0;
    end else if (nwr == RCW_NWR_FOUR) begin
      m = 8'hc0 >> {pos, 1'b0};
    end
    return m;
  endfunction

endpackage

// [rcw_spi_slave.sv]
`timescale 1ns/1ps
module rcw_spi_slave
  import rcw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclkPin,
  input wire logic csPin_b,
  input wire logic mosiPin,
  input wire logic [7:0] txLow,
  output logic misoOut,
  output logic misoOe,
  output logic cmdValid,
  output logic [7:0] cmdByte,
  output logic frameDone,
  output logic [15:0] rxWord
);

  logic [2:0] sclkSync_ff;
  logic [2:0] csSync_ff;
  logic [1:0] mosiSync_ff;
  logic [4:0] bitCnt_ff;
  logic [15:0] rxSh_ff;
  logic [7:0] txSh_ff;
  logic sclkRise;
  logic sclkFall;
  logic csFall;
  logic csRise;

  // two flops before use; the third stage only serves edge detection
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sclkSync_ff <= 3'h0;
      csSync_ff <= 3'h7;
      mosiSync_ff <= 2'h0;
    end else begin
      sclkSync_ff <= {sclkSync_ff[1:0], sclkPin};
      csSync_ff <= {csSync_ff[1:0], csPin_b};
      mosiSync_ff <= {mosiSync_ff[0], mosiPin};
    end
  end

  assign sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2] & ~csSync_ff[1];
  assign sclkFall = ~sclkSync_ff[1] & sclkSync_ff[2] & ~csSync_ff[1];
  assign csFall = ~csSync_ff[1] & csSync_ff[2];
  assign csRise = csSync_ff[1] & ~csSync_ff[2];
  assign misoOe = ~csSync_ff[1];

  // receive side, msb first, sampled on rising clock
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bitCnt_ff <= 5'h00;
      rxSh_ff <= 16'h0000;
      cmdValid <= 1'b0;
      cmdByte <= 8'h00;
      frameDone <= 1'b0;
      rxWord <= 16'h0000;
    end else begin
      cmdValid <= 1'b0;
      frameDone <= 1'b0;
      if (csFall) begin
        bitCnt_ff <= 5'h00;
      end else if (sclkRise && bitCnt_ff < 5'(FRAME_BITS)) begin
        rxSh_ff <= {rxSh_ff[14:0], mosiSync_ff[1]};
        bitCnt_ff <= bitCnt_ff + 5'h01;
        if (bitCnt_ff == 5'(CMD_BITS - 1)) begin
          cmdValid <= 1'b1;
          cmdByte <= {rxSh_ff[6:0], mosiSync_ff[1]};
        end
      end
      // a frame shorter than 16 bits is dropped silently; clocks past the 16th are ignored and the frame is kept
      if (csRise && bitCnt_ff == 5'(FRAME_BITS)) begin
        frameDone <= 1'b1;
        rxWord <= rxSh_ff;
      end
    end
  end

  // transmit side, changes on falling clock; low byte picked once the command is known
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txSh_ff <= 8'h00;
      misoOut <= 1'b0;
    end else if (csFall) begin
      misoOut <= STATUS_HIGH[7];
      txSh_ff <= {STATUS_HIGH[6:0], 1'b0};
    end else if (sclkFall) begin
      if (bitCnt_ff == 5'(CMD_BITS)) begin
        misoOut <= txLow[7];
        txSh_ff <= {txLow[6:0], 1'b0};
      end else begin
        misoOut <= txSh_ff[7];
        txSh_ff <= {txSh_ff[6:0], 1'b0};
      end
    end
  end

endmodule

// [rcw_watchdog_refresh.sv]
`timescale 1ns/1ps
// Functional notes
// - single write returns a fresh challenge
// - two writes carry high nibble then low
// - two-write new challenge only on second write
// - four writes carry two bits each, msb first
// - four-write new challenge on fourth write
// - interrupt supervision only when enabled
// - sleep-supply mode keeps regulator, reduced current
// - transceiver supply on after debug power-up
// - high-side io0/io1 stay on through reset modes
// - low-side io0 off in reset, restored later
// - low-side io1 stays on through reset modes
// - init reset: bus transceiver off, terminated
// - init reset: single-wire pull-up only
// - open window spans second half of period
// - early or missing refresh forces reset outside debug
module rcw_watchdog_refresh
  import rcw_pkg::*;
#(
  parameter int PERIOD_CYC = WD_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclkPin,
  input wire logic csPin_b,
  input wire logic mosiPin,
  output logic misoOut,
  output logic misoOe,
  input wire logic wdRun,
  input wire logic advancedSel,
  input wire logic windowSel,
  input wire rcw_nwr_t nwrSel,
  input wire logic intSuperviseEn,
  input wire logic intRequest,
  input wire logic debugMode,
  input wire rcw_mode_t devMode,
  input wire rcw_iocfg_t io0Cfg,
  input wire logic io0OnNormal,
  input wire rcw_iocfg_t io1Cfg,
  input wire logic io1OnNormal,
  input wire logic canSupplyWr,
  input wire logic canSupplyVal,
  input wire logic [7:0] normalCanLin,
  output logic wdFail,
  output logic resetReq,
  output logic [7:0] challenge,
  output logic [1:0] seqPos,
  output rcw_map_t blockMap
);

  localparam int CW = 32;
  localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(PERIOD_CYC / 2);
  localparam logic [CW-1:0] INT_LIMIT = CW'(INT_PERIODS * PERIOD_CYC - 1);

  // the window and timer compares need a period of a few cycles at least
  if (PERIOD_CYC < 4) begin : g_period_check
    $error("period too short");
  end

  logic [7:0] cmdByte;
  logic frameDone;
  logic [15:0] rxWord;
  logic [7:0] txLow;
  logic [7:0] candidate;
  logic [CW-1:0] wdCnt_ff;
  logic [CW-1:0] intCnt_ff;
  logic intWait_ff;
  logic canSup_ff;
  logic strapDone_ff;
  logic dbgSync1_ff;
  logic dbgSync2_ff;
  logic [1:0] lastPos;
  logic isRefresh;
  logic lastWrite;
  logic payloadOk;
  logic earlyHit;
  logic timeout;
  logic intLate;
  logic intAccess;
  logic failNow;
  logic refreshDone;
  logic inResetGroup;
  rcw_map_t nxt_map;

  rcw_spi_slave u_spi (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sclkPin(sclkPin),
    .csPin_b(csPin_b),
    .mosiPin(mosiPin),
    .txLow(txLow),
    .misoOut(misoOut),
    .misoOe(misoOe),
    .cmdValid(),
    .cmdByte(cmdByte),
    .frameDone(frameDone),
    .rxWord(rxWord)
  );

  // next challenge is precomputed so it can go out before the frame ends
  assign candidate = challenge[0] ? ((challenge >> 1) ^ LFSR_TAPS) : (challenge >> 1);
  assign lastPos = advancedSel ? 2'(nwrSel) : 2'h0;
  assign lastWrite = (seqPos == lastPos);
  // the fresh code goes out only on the closing write of a refresh
  assign txLow = (cmdByte == CMD_REFRESH && lastWrite) ? candidate : challenge;

  // payload check against the inverted bits for this position
  assign isRefresh = frameDone && wdRun && rxWord[15:8] == CMD_REFRESH;
  assign payloadOk = !advancedSel ||
    (rxWord[7:0] == (~challenge & rcw_mask(nwrSel, seqPos)));
  // only the closing write is held against the window
  assign earlyHit = windowSel && lastWrite && wdCnt_ff < HALF;
  assign refreshDone = isRefresh && payloadOk && !earlyHit && lastWrite;
  assign timeout = wdRun && wdCnt_ff == PERIOD_LAST;
  assign intAccess = frameDone && rxWord[15:9] == INT_REG_ADDR;
  assign intLate = intWait_ff && intCnt_ff == INT_LIMIT && !intAccess;
  assign failNow = (isRefresh && (!payloadOk || earlyHit)) || timeout || intLate;

  // period counter restarts on a good refresh or a failure
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !wdRun || refreshDone || failNow) begin
      wdCnt_ff <= '0;
    end else begin
      wdCnt_ff <= wdCnt_ff + CW'(1);
    end
  end

  // position of the next expected partial write
  always_ff @(posedge clk_sys) begin
    if (!rst_b || failNow || refreshDone || !wdRun) begin
      seqPos <= 2'h0;
    end else if (isRefresh && payloadOk) begin
      seqPos <= seqPos + 2'h1;
    end
  end

  // challenge advances only when the refresh that showed it completes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      challenge <= LFSR_SEED;
    end else if (refreshDone && advancedSel) begin
      challenge <= candidate;
    end
  end

  // interrupt response timer, armed only with supervision enabled
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !intSuperviseEn || !wdRun) begin
      intWait_ff <= 1'b0;
      intCnt_ff <= '0;
    end else if (intAccess || intLate) begin
      intWait_ff <= 1'b0;
      intCnt_ff <= '0;
    end else if (intRequest && !intWait_ff) begin
      intWait_ff <= 1'b1;
      intCnt_ff <= '0;
    end else if (intWait_ff) begin
      intCnt_ff <= intCnt_ff + CW'(1);
    end
  end

  // failure pulse; debug keeps the watchdog running but never resets
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wdFail <= 1'b0;
      resetReq <= 1'b0;
    end else begin
      wdFail <= failNow;
      resetReq <= failNow && !dbgSync2_ff;
    end
  end

  // debug strap comes from a pin, so it is synchronised first
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dbgSync1_ff <= 1'b0;
      dbgSync2_ff <= 1'b0;
    end else begin
      dbgSync1_ff <= debugMode;
      dbgSync2_ff <= dbgSync1_ff;
    end
  end

  // supply default caught after release, then freely written
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      canSup_ff <= 1'b0;
      strapDone_ff <= 1'b0;
    end else if (canSupplyWr) begin
      canSup_ff <= canSupplyVal;
      strapDone_ff <= 1'b1;
    end else if (!strapDone_ff && devMode != RCW_MODE_INIT_RESET && devMode != RCW_MODE_PWR_DOWN) begin
      canSup_ff <= dbgSync2_ff;
      strapDone_ff <= 1'b1;
    end
  end

  assign inResetGroup = devMode == RCW_MODE_RESET || devMode == RCW_MODE_INIT ||
    devMode == RCW_MODE_NORM_REQ;

  // per-mode switch map; normalCanLin holds the software view of the bus blocks
  always_comb begin
    nxt_map = '0;
    unique case (devMode)
      RCW_MODE_PWR_DOWN, RCW_MODE_LP_OFF, RCW_MODE_SAFE: begin
        nxt_map.vddOn = devMode == RCW_MODE_SAFE;
      end
      RCW_MODE_INIT_RESET: begin
        nxt_map.vddOn = 1'b1;
        nxt_map.canTermGnd = 1'b1;
        nxt_map.linPullup = 1'b1;
      end
      RCW_MODE_INIT, RCW_MODE_RESET, RCW_MODE_NORM_REQ: begin
        nxt_map.vddOn = 1'b1;
        nxt_map.canSupplyOn = canSup_ff;
        nxt_map.io0Hs = io0Cfg == RCW_IO_HS && io0OnNormal;
        nxt_map.io1Hs = io1Cfg == RCW_IO_HS && io1OnNormal;
        nxt_map.io0Ls = devMode != RCW_MODE_RESET &&
          io0Cfg == RCW_IO_LS && io0OnNormal;
        nxt_map.io1Ls = io1Cfg == RCW_IO_LS && io1OnNormal;
      end
      RCW_MODE_NORMAL, RCW_MODE_FLASH: begin
        nxt_map.vddOn = 1'b1;
        nxt_map.canSupplyOn = canSup_ff;
        nxt_map.io0Hs = io0Cfg == RCW_IO_HS && io0OnNormal;
        nxt_map.io1Hs = io1Cfg == RCW_IO_HS && io1OnNormal;
        nxt_map.io0Ls = io0Cfg == RCW_IO_LS && io0OnNormal;
        nxt_map.io1Ls = io1Cfg == RCW_IO_LS && io1OnNormal;
        nxt_map.canTxEn = normalCanLin[0];
        nxt_map.canRxEn = normalCanLin[1];
        nxt_map.canWakeEn = normalCanLin[2];
        nxt_map.linPullup = devMode == RCW_MODE_NORMAL && normalCanLin[3];
        nxt_map.linTxEn = devMode == RCW_MODE_NORMAL && normalCanLin[4];
        nxt_map.linRxEn = devMode == RCW_MODE_NORMAL && normalCanLin[5];
        nxt_map.linWakeEn = devMode == RCW_MODE_NORMAL && normalCanLin[6];
        nxt_map.linTermEn = devMode == RCW_MODE_NORMAL && normalCanLin[7];
      end
      RCW_MODE_SLEEP_KEPT: begin
        nxt_map.vddOn = 1'b1;
        nxt_map.vddLowCurrent = 1'b1;
      end
      default: begin
        nxt_map = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      blockMap <= '0;
    end else begin
      blockMap <= nxt_map;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_early_fails: assert property (isRefresh && lastWrite && windowSel && wdCnt_ff < HALF
    |=> wdFail) else $error("early refresh not failed");
  a_timeout_fails: assert property (wdRun && wdCnt_ff == PERIOD_LAST
    |=> wdFail ##1 (wdCnt_ff <= CW'(2))) else $error("timeout not failed");
  a_bad_payload: assert property (isRefresh && advancedSel &&
    rxWord[7:0] != (~challenge & rcw_mask(nwrSel, seqPos)) |=> wdFail && seqPos == 2'h0)
    else $error("bad payload accepted");
  a_seq_clear: assert property (refreshDone |=> seqPos == 2'h0)
    else $error("position not cleared");
  a_challenge_hold: assert property (frameDone && !refreshDone |=> $stable(challenge))
    else $error("challenge changed without refresh");
  a_challenge_new: assert property (refreshDone && advancedSel
    |=> challenge == $past(candidate)) else $error("challenge not renewed");
  a_int_off: assert property (!intSuperviseEn |=> !intWait_ff)
    else $error("interrupt supervised while disabled");
  a_sleep_supply: assert property (devMode == RCW_MODE_SLEEP_KEPT
    |=> blockMap.vddOn && blockMap.vddLowCurrent) else $error("sleep supply wrong");
  a_io0_ls_reset: assert property (devMode == RCW_MODE_RESET |=> !blockMap.io0Ls)
    else $error("low-side io0 on in reset");
  a_init_reset_bus: assert property (devMode == RCW_MODE_INIT_RESET |=> blockMap.canTermGnd
    && blockMap.linPullup && !blockMap.canTxEn && !blockMap.linTermEn)
    else $error("init reset bus state wrong");

  c_refresh: cover property (refreshDone && nwrSel == RCW_NWR_FOUR);
  c_fail: cover property (wdFail);
  c_int_late: cover property (intLate);

endmodule

// [rcw_host_model.sv]
`timescale 1ns/1ps
// host side of the serial link: mode 0 master, 100 ns half period, msb first
module rcw_host_model (
  input wire logic clk_sys,
  output logic sclkPin,
  output logic csPin_b,
  output logic mosiPin,
  input wire logic misoOut,
  input wire logic misoOe,
  output logic [15:0] rxWord,
  output logic done
);
  logic mosiDrv;
  logic idlePat = 1'b0;

  // a released data line toggles so that a stale bit can never pass for data
  always @(posedge clk_sys) idlePat <= ~idlePat;
  assign mosiPin = csPin_b ? idlePat : mosiDrv;

  initial begin
    sclkPin = 1'b0;
    csPin_b = 1'b1;
    mosiDrv = 1'b0;
    rxWord = '0;
    done = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // one whole 16-bit frame; miso only counts while its enable is up
  task automatic xfer(input logic [15:0] w);
    @(posedge clk_sys);
    #1;
    csPin_b = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosiDrv = w[i];
      half();
      rxWord[i] = misoOe ? misoOut : 1'bx;
      sclkPin = 1'b1;
      half();
      sclkPin = 1'b0;
    end
    half();
    csPin_b = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    done = 1'b1;
    @(posedge clk_sys);
    #1;
    done = 1'b0;
  endtask
endmodule

// [test_random_code_watchdog_refresh.sv]
`timescale 1ns/1ps
module test_random_code_watchdog_refresh;
  import rcw_pkg::*;
  localparam int PER = 1024;
  typedef struct packed {
    logic [15:0] v;
    logic [15:0] m;
  } rcw_exp_t;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sclkPin, csPin_b, mosiPin, misoOut, misoOe, hostDone;
  logic wdRun = 1'b0;
  logic advancedSel = 1'b0;
  logic windowSel = 1'b0;
  rcw_nwr_t nwrSel = RCW_NWR_ONE;
  logic intSuperviseEn = 1'b0;
  logic intRequest = 1'b1;
  logic debugMode = 1'b1;
  rcw_mode_t devMode = RCW_MODE_PWR_DOWN;
  rcw_iocfg_t io0Cfg = RCW_IO_OFF;
  rcw_iocfg_t io1Cfg = RCW_IO_OFF;
  logic io0OnNormal = 1'b0;
  logic io1OnNormal = 1'b0;
  logic canSupplyWr = 1'b0;
  logic canSupplyVal = 1'b0;
  logic [7:0] normalCanLin = 8'h00;
  logic wdFail, resetReq;
  logic [7:0] challenge;
  logic [1:0] seqPos;
  logic [15:0] rxWord;
  rcw_map_t blockMap;
  rcw_map_t e;
  int errCount = 0;
  int nChecks = 0;
  int failCnt = 0;
  int rstCnt = 0;
  logic [31:0] rs = 32'h33;
  logic [7:0] ch;
  rcw_exp_t expQ[$];
  rcw_mode_t hsModes[3] = '{RCW_MODE_RESET, RCW_MODE_INIT, RCW_MODE_NORM_REQ};

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  rcw_watchdog_refresh #(.PERIOD_CYC(PER)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .sclkPin(sclkPin), .csPin_b(csPin_b), .mosiPin(mosiPin), .misoOut(misoOut),
    .misoOe(misoOe), .wdRun(wdRun), .advancedSel(advancedSel), .windowSel(windowSel),
    .nwrSel(nwrSel), .intSuperviseEn(intSuperviseEn), .intRequest(intRequest),
    .debugMode(debugMode), .devMode(devMode), .io0Cfg(io0Cfg), .io0OnNormal(io0OnNormal),
    .io1Cfg(io1Cfg), .io1OnNormal(io1OnNormal), .canSupplyWr(canSupplyWr),
    .canSupplyVal(canSupplyVal), .normalCanLin(normalCanLin), .wdFail(wdFail),
    .resetReq(resetReq), .challenge(challenge), .seqPos(seqPos), .blockMap(blockMap));

  rcw_host_model host (.clk_sys(clk_sys), .sclkPin(sclkPin), .csPin_b(csPin_b),
    .mosiPin(mosiPin), .misoOut(misoOut), .misoOe(misoOe), .rxWord(rxWord), .done(hostDone));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] a, input logic [15:0] x);
    nChecks++;
    if (a !== x) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, a, x);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic mode(input rcw_mode_t m);
    devMode = m;
    tick(3);
  endtask

  // pulses are one cycle wide, so they are counted on every edge
  always @(posedge clk_sys) begin
    if (wdFail === 1'b1) failCnt++;
    if (resetReq === 1'b1) rstCnt++;
  end

  // oldest note against each finished frame's miso word
  always @(posedge hostDone) begin
    rcw_exp_t x;
    if (expQ.size() > 0) begin
      x = expQ.pop_front();
      chk(rxWord & x.m, x.v & x.m);
    end
  end

  // one refresh split over n writes; badK spoils that write, early skips the window
  task automatic refresh(input rcw_nwr_t n, input int badK, input bit early);
    int cnt;
    int f0;
    logic [7:0] m;
    logic [7:0] pay;
    logic [7:0] old;
    bit last;
    bit fail;
    cnt = (n == RCW_NWR_ONE) ? 1 : ((n == RCW_NWR_TWO) ? 2 : 4);
    nwrSel = n;
    old = ch;
    for (int k = 0; k < cnt; k++) begin
      m = (cnt == 1) ? 8'hff : ((cnt == 2) ? (k ? 8'h0f : 8'hf0) : (8'hc0 >> (2 * k)));
      pay = ~ch & m;
      if (k == badK) pay = pay ^ m;
      last = (k == cnt - 1);
      fail = (k == badK) || (last && early);
      f0 = failCnt;
      expQ.push_back({{8'h00, old}, last ? 16'hff00 : 16'hffff});
      host.xfer({CMD_REFRESH, pay});
      chk(16'(failCnt - f0), 16'(fail));
      if (fail || !last) begin
        chk({8'h00, challenge}, {8'h00, old});
      end else begin
        chk({8'h00, challenge}, {8'h00, rxWord[7:0]});
        chk(16'(challenge == old), 16'h0000);
        ch = rxWord[7:0];
      end
      chk({14'h0, seqPos}, (fail || last) ? 16'h0 : 16'(k + 1));
      if (fail) break;
      tick(int'(rnd() % 8));
    end
  endtask

  initial begin
    int f0;
    int r0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    tick(3);
    chk({8'h00, challenge}, {8'h00, LFSR_SEED});
    chk({14'h0, seqPos}, 16'h0);
    // per-mode map, powered up in debug
    mode(RCW_MODE_INIT_RESET);
    e = '0;
    e.vddOn = 1'b1;
    e.canTermGnd = 1'b1;
    e.linPullup = 1'b1;
    chk(blockMap, e);
    mode(RCW_MODE_INIT);
    chk(16'(blockMap.canSupplyOn), 16'h1);
    mode(RCW_MODE_NORMAL);
    for (int v = 0; v < 2; v++) begin
      canSupplyVal = v[0];
      canSupplyWr = 1'b1;
      tick(1);
      canSupplyWr = 1'b0;
      tick(3);
      chk(16'(blockMap.canSupplyOn), 16'(v));
    end
    normalCanLin = 8'(rnd());
    tick(3);
    chk({blockMap.linTermEn, blockMap.linWakeEn, blockMap.linRxEn, blockMap.linTxEn,
         blockMap.linPullup, blockMap.canWakeEn, blockMap.canRxEn, blockMap.canTxEn},
        normalCanLin);
    io0Cfg = RCW_IO_LS;
    io1Cfg = RCW_IO_LS;
    io0OnNormal = 1'b1;
    io1OnNormal = 1'b1;
    tick(3);
    chk({blockMap.io0Ls, blockMap.io1Ls}, 16'h3);
    mode(RCW_MODE_RESET);
    chk({blockMap.io0Ls, blockMap.io1Ls}, 16'h1);
    mode(RCW_MODE_NORMAL);
    chk({blockMap.io0Ls, blockMap.io1Ls}, 16'h3);
    io0Cfg = RCW_IO_HS;
    io1Cfg = RCW_IO_HS;
    tick(3);
    foreach (hsModes[i]) begin
      mode(hsModes[i]);
      chk({blockMap.io0Hs, blockMap.io1Hs}, 16'h3);
    end
    mode(RCW_MODE_SLEEP_KEPT);
    chk({blockMap.vddOn, blockMap.vddLowCurrent}, 16'h3);
    // remaining modes: flash keeps the bus transceiver but not the single-wire one
    mode(RCW_MODE_FLASH);
    chk({blockMap.linTxEn, blockMap.canTxEn}, {15'h0000, normalCanLin[0]});
    mode(RCW_MODE_SAFE);
    chk(16'(blockMap.vddOn), 16'h0001);
    mode(RCW_MODE_LP_OFF);
    chk(blockMap, 16'h0000);
    mode(RCW_MODE_NORMAL);
    debugMode = 1'b0;
    tick(4);
    // challenge read first, then refreshes of every split; the pending
    // interrupt must stay harmless while supervision is off
    expQ.push_back({{8'h00, LFSR_SEED}, 16'hffff});
    host.xfer({CMD_RD_RANDOM, 8'h00});
    ch = rxWord[7:0];
    advancedSel = 1'b1;
    wdRun = 1'b1;
    refresh(RCW_NWR_ONE, -1, 1'b0);
    refresh(RCW_NWR_TWO, -1, 1'b0);
    refresh(RCW_NWR_FOUR, -1, 1'b0);
    refresh(RCW_NWR_FOUR, 1, 1'b0);
    refresh(RCW_NWR_TWO, 1, 1'b0);
    refresh(RCW_NWR_ONE, 0, 1'b0);
    windowSel = 1'b1;
    refresh(RCW_NWR_ONE, -1, 1'b1);
    tick(PER / 2 - 62);
    refresh(RCW_NWR_ONE, -1, 1'b0);
    tick(100);
    refresh(RCW_NWR_FOUR, -1, 1'b0);
    tick(400);
    refresh(RCW_NWR_TWO, -1, 1'b0);
    windowSel = 1'b0;
    f0 = failCnt;
    r0 = rstCnt;
    tick(PER + 76);
    chk(16'(failCnt - f0), 16'h1);
    chk(16'(rstCnt - r0), 16'h1);
    // simple refresh with supervision on: interrupt register touched every
    // ~290 cycles stays in time, then 16 bare refreshes outlast two periods
    advancedSel = 1'b0;
    intSuperviseEn = 1'b1;
    f0 = failCnt;
    for (int i = 0; i < 24; i++) begin
      if (i < 8) begin
        expQ.push_back({{8'h00, ch}, 16'hffff});
        host.xfer({INT_REG_ADDR, 1'b0, 8'h00});
      end
      expQ.push_back({16'h0000, 16'hff00});
      host.xfer({CMD_REFRESH, 8'h00});
      if (i == 7) begin
        chk(16'(failCnt - f0), 16'h0000);
        f0 = failCnt;
      end
    end
    chk(16'(failCnt - f0), 16'h0001);
    chk({8'h00, challenge}, {8'h00, ch});
    conclude();
  end

  // the whole sequence needs about ten thousand cycles, so twice that is ample
  initial begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    conclude();
  end
endmodule
